/* File: aidr_chk.sv */
// Purpose: port checker for the identity/status bank
// Assumes: one clock, reset active low
// Notes: bound onto every aidr_regs
`timescale 1ns/1ps
`default_nettype none
module aidr_chk #(parameter [3:0] ID_FAMILY = 4'h5) (
    // Clock, reset, register port
    input wire sys_clk, input wire resetn, input wire clk_en,
    input wire [5:0] reg_addr, input wire [15:0] reg_wdata,
    input wire reg_wr, input wire reg_rd, input wire [15:0] reg_rdata,
    // Events and outputs
    input wire if_locked, input wire resync_pulse, input wire rx_crc_error,
    input wire [7:0] conv_done, input wire [7:0] result_taken,
    input wire crc_type, input wire [1:0] word_length_field,
    input wire [7:0] channel_new_data_flag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire st = reg_rd && clk_en && reg_addr == 6'h01;
    sequence s_mwr;
        reg_wr && clk_en && reg_addr == 6'h02 ##1 clk_en && !reg_wr;
    endsequence
    property p_id;
        reg_rd && clk_en && reg_addr == 6'h00
        |=> reg_rdata[15:8] == {ID_FAMILY, 4'h8};
    endproperty
    a_id: assert property (p_id) else $error("id byte wrong");
    property p_lock;
        st && $past(resetn && clk_en) && $past(if_locked) == if_locked
        |=> reg_rdata[15] == $past(if_locked);
    endproperty
    a_lock: assert property (p_lock) else $error("lock bit wrong");
    property p_rsy;
        st && $past(resetn && clk_en && resync_pulse) |=> reg_rdata[14];
    endproperty
    a_rsy: assert property (p_rsy) else $error("resync lost");
    property p_crce;
        st && $past(resetn && clk_en && rx_crc_error) |=> reg_rdata[12];
    endproperty
    a_crce: assert property (p_crce) else $error("crc err lost");
    property p_ctype;
        s_mwr |=> crc_type == $past(reg_wdata[11], 2)
            && word_length_field == $past(reg_wdata[9:8], 2);
    endproperty
    a_ctype: assert property (p_ctype) else $error("mode copy");
    property p_mode;
        reg_rd && clk_en && reg_addr == 6'h02 |=> reg_rdata[11] == crc_type
            && reg_rdata[9:8] == word_length_field;
    endproperty
    a_mode: assert property (p_mode) else $error("mode read");
    property p_set;
        clk_en |=> (channel_new_data_flag & $past(conv_done))
            == $past(conv_done);
    endproperty
    a_set: assert property (p_set) else $error("flag not set");
    property p_clr;
        clk_en |=> (channel_new_data_flag
            & $past(result_taken & ~conv_done)) == 8'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("flag kept");
    property p_st;
        st |=> reg_rdata[7:0] == $past(channel_new_data_flag);
    endproperty
    a_st: assert property (p_st) else $error("status flags");
endmodule
bind aidr_regs aidr_chk #(.ID_FAMILY(ID_FAMILY)) chk_u (.sys_clk, .resetn,
    .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .if_locked, .resync_pulse, .rx_crc_error, .conv_done, .result_taken,
    .crc_type, .word_length_field, .channel_new_data_flag);
`default_nettype wire

/* File: aidr_defines.vh */
// Purpose: constants for the ADC identity and status register bank
// Assumes: 16-bit registers, word addressed
// Notes: included by aidr_regs.v
`ifndef AIDR_DEFINES_VH
`define AIDR_DEFINES_VH
`define AIDR_ADDR_W 6
`define AIDR_DATA_W 16
`define AIDR_OFS_ID 6'h00
`define AIDR_OFS_STATUS 6'h01
`define AIDR_OFS_MODE 6'h02
`define AIDR_OFS_IRQ_STAT 6'h30
`define AIDR_OFS_IRQ_EN 6'h31
`define AIDR_OFS_IRQ_CLR 6'h32
`define AIDR_OFS_EVT_SRC 6'h33
`define AIDR_ID_FAMILY_LSB 12
`define AIDR_ID_CHANNEL_COUNT_FIELD_LSB 8
`define AIDR_CHANNEL_COUNT_FIELD_VAL 4'h8
`define AIDR_ST_LOCK 15
`define AIDR_ST_RESYNC 14
`define AIDR_ST_REGMAP 13
`define AIDR_ST_CRCERR 12
`define AIDR_ST_CRCTYPE 11
`define AIDR_ST_RESET 10
`define AIDR_ST_WLEN_LSB 8
`define AIDR_MODE_CRCTYPE 11
`define AIDR_MODE_RESET 10
`define AIDR_MODE_WLEN_LSB 8
`define AIDR_MODE_RST 16'h0510
`define AIDR_STATUS_RST 16'h0500
`define AIDR_NUM_CH 8
`define AIDR_NUM_EVT 4
`define AIDR_LOCK_RST 1'b0
`define AIDR_FLAG_RST 1'b0
`define AIDR_RESETFLAG_RST 1'b1
`define AIDR_CRCTYPE_RST 1'b0
`define AIDR_WLEN_RST 2'b01
`define AIDR_EVT_RESYNC 0
`define AIDR_EVT_CRCERR 1
`define AIDR_EVT_NEWDATA 2
`define AIDR_EVT_LOCK 3
`endif

/* File: aidr_host.sv */
// Purpose: host side register master
// Assumes: read data stand one cycle after the strobe
// Notes: write data inverted when idle, so stale data never match
`timescale 1ns/1ps
`default_nettype none
module aidr_host (
    input wire sys_clk,
    output logic [5:0] reg_addr = 6'h00,
    output logic [15:0] reg_wdata = 16'h0000,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    input wire [15:0] reg_rdata
);
    task wr(input [5:0] a, input [15:0] d);
        @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge sys_clk) {reg_wdata, reg_wr} <= {~d, 1'b0};
    endtask
    task rd(input [5:0] a, output [15:0] q);
        @(posedge sys_clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge sys_clk) reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* File: aidr_regs.v */
// What this block does
// - ID at zero, read-only, writes ignored
// - ID bits 15:12 fixed identity nibble
// - ID bits 11:8 read channel count 1000b
// - Status at one, read-only, resets 0500h
// - Status bit 15 shows interface lock
// - Status bit 14 set on resync
// - Status bit 13 shows register-map CRC change
// - Status bit 12 set on input CRC error
// - Status bit 11 shows CRC polynomial
// - Status bit 10 shows reset occurred
// - Status bits 9:8 show word length
// - Status bits 7:0 per-channel new data
// - Mode at two, mirrored fields, resets 0510h
//
// Purpose: identity, status and mode registers of an 8-channel ADC
// Assumes: single clock; host strobes are one cycle long
//   Event inputs are single-cycle pulses in the sys_clk domain
//   Host never raises write and read strobes together
// Notes: sticky flags give set priority over clear
//   Resync and input CRC error flags clear only on reset
//   Status mirrors mode fields at once; crc_type and
//   word_length_field lag one cycle behind the mode image
//   A low clock enable also drops event pulses, by design
//   Interrupt bookkeeping is local to this bank, not the
//   converter's own data-ready pin
//   Every top output comes straight from a flip-flop
`timescale 1ns/1ps
`default_nettype none
`include "aidr_defines.vh"

module aidr_regs #(
    // Arbitrary value, identifies nothing real
    parameter [3:0] ID_FAMILY = 4'h5,
    // Arbitrary revision value
    parameter [7:0] ID_REVISION = 8'h01
) (
    // Clock and reset
    input wire sys_clk,
    input wire resetn,
    input wire clk_en,
    // Register port
    input wire [`AIDR_ADDR_W-1:0] reg_addr,
    input wire [`AIDR_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`AIDR_DATA_W-1:0] reg_rdata,
    // Converter and checker events
    input wire if_locked,
    input wire resync_pulse,
    input wire regmap_crc_changed,
    input wire rx_crc_error,
    input wire [`AIDR_NUM_CH-1:0] conv_done,
    input wire [`AIDR_NUM_CH-1:0] result_taken,
    // Mode and new-data flag outputs to the core
    output reg crc_type,
    output reg [1:0] word_length_field,
    output reg [`AIDR_NUM_CH-1:0] channel_new_data_flag,
    // Interrupt
    output reg irq
);

    reg lock_r;
    reg resync_flag_r;
    reg regmap_flag_r;
    reg crcerr_flag_r;
    reg reset_flag_r;
    reg [`AIDR_DATA_W-1:0] mode_r;
    reg [`AIDR_NUM_EVT-1:0] irq_stat_r;
    reg [`AIDR_NUM_EVT-1:0] irq_en_r;
    reg [`AIDR_DATA_W-1:0] rdata_nxt;
    wire [`AIDR_DATA_W-1:0] status_w;
    wire [`AIDR_NUM_EVT-1:0] evt_w;
    wire [`AIDR_NUM_EVT-1:0] irq_clr_w;
    wire wr_mode;
    wire irq_nxt;
    // Next values of the state above, one always block each
    // so every register has a single, easily traced source
    reg [`AIDR_DATA_W-1:0] rd_out_nxt;
    reg [`AIDR_DATA_W-1:0] mode_nxt;
    reg reset_flag_nxt;
    reg resync_flag_nxt;
    reg crcerr_flag_nxt;
    reg [`AIDR_NUM_EVT-1:0] irq_en_nxt;
    reg [`AIDR_NUM_EVT-1:0] irq_stat_nxt;
    // Decoded write strobes
    wire wr_irq_en;
    wire wr_irq_clr;

    // writes to the ID and status offsets decode to nothing
    assign wr_mode = reg_wr && (reg_addr == `AIDR_OFS_MODE);
    assign wr_irq_en = reg_wr && (reg_addr == `AIDR_OFS_IRQ_EN);
    assign wr_irq_clr = reg_wr && (reg_addr == `AIDR_OFS_IRQ_CLR);
    // Clear register is write-one-to-clear and reads zero
    assign irq_clr_w = wr_irq_clr ? reg_wdata[`AIDR_NUM_EVT-1:0] :
        {`AIDR_NUM_EVT{1'b0}};

    // Event sources of the interrupt status bits
    assign evt_w[`AIDR_EVT_RESYNC] = resync_pulse;
    assign evt_w[`AIDR_EVT_CRCERR] = rx_crc_error;
    // Any channel finishing counts once, whatever the count
    assign evt_w[`AIDR_EVT_NEWDATA] = |conv_done;
    // Lock change in either direction against the last sampled level
    assign evt_w[`AIDR_EVT_LOCK] = lock_r ^ if_locked;

    assign status_w = {lock_r, resync_flag_r, regmap_flag_r,
                       crcerr_flag_r, mode_r[`AIDR_MODE_CRCTYPE],
                       reset_flag_r,
                       mode_r[`AIDR_MODE_WLEN_LSB+1:`AIDR_MODE_WLEN_LSB],
                       channel_new_data_flag};

    // Read mux; unmapped and write-only offsets read zero
    // Decoding is full on the six address bits, so no alias of a
    // register shows up at a higher offset
    always @* begin
        rdata_nxt = {`AIDR_DATA_W{1'b0}};
        case (reg_addr)
            `AIDR_OFS_ID: begin
                rdata_nxt = {ID_FAMILY, `AIDR_CHANNEL_COUNT_FIELD_VAL, ID_REVISION};
            end
            `AIDR_OFS_STATUS: begin
                rdata_nxt = status_w;
            end
            `AIDR_OFS_MODE: begin
                rdata_nxt = {mode_r[15:11], reset_flag_r, mode_r[9:0]};
            end
            `AIDR_OFS_IRQ_STAT: begin
                rdata_nxt[`AIDR_NUM_EVT-1:0] = irq_stat_r;
            end
            `AIDR_OFS_IRQ_EN: begin
                rdata_nxt[`AIDR_NUM_EVT-1:0] = irq_en_r;
            end
            default: begin
                rdata_nxt = {`AIDR_DATA_W{1'b0}};
            end
        endcase
    end

    // Interrupt output follows enabled sticky bits, one cycle late
    assign irq_nxt = |(irq_stat_r & irq_en_r);

    // resync flag is sticky; no host clear exists
    always @* begin
        resync_flag_nxt = resync_flag_r;
        if (resync_pulse) begin
            resync_flag_nxt = 1'b1;
        end
    end

    // input CRC error flag is sticky as well
    always @* begin
        crcerr_flag_nxt = crcerr_flag_r;
        if (rx_crc_error) begin
            crcerr_flag_nxt = 1'b1;
        end
    end

    // mode image; the whole word is kept for readback
    always @* begin
        mode_nxt = mode_r;
        if (wr_mode) begin
            mode_nxt = reg_wdata;
        end
    end

    // reset flag; only a mode write can lower it
    always @* begin
        reset_flag_nxt = reset_flag_r;
        if (wr_mode) begin
            reset_flag_nxt = reg_wdata[`AIDR_MODE_RESET];
        end
    end

    // Interrupt enable takes the low event bits only
    always @* begin
        irq_en_nxt = irq_en_r;
        if (wr_irq_en) begin
            irq_en_nxt = reg_wdata[`AIDR_NUM_EVT-1:0];
        end
    end

    // Set wins over a clear in the same cycle, so no event is lost
    always @* begin
        irq_stat_nxt = irq_stat_r & ~irq_clr_w;
        irq_stat_nxt = irq_stat_nxt | evt_w;
    end

    // Read data stand one cycle after the strobe, zero otherwise;
    // a zero idle value keeps stale data off the bus
    always @* begin
        rd_out_nxt = {`AIDR_DATA_W{1'b0}};
        if (reg_rd) begin
            rd_out_nxt = rdata_nxt;
        end
    end

    // Read data register; the host never waits, so no
    // handshake beyond the one-cycle latency exists
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= {`AIDR_DATA_W{1'b0}};
        end else if (clk_en) begin
            reg_rdata <= rd_out_nxt;
        end
    end

    // lock level, one cycle behind the pin
    // status word and lock-change event share this sample
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lock_r <= `AIDR_LOCK_RST;
        end else if (clk_en) begin
            lock_r <= if_locked;
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            resync_flag_r <= `AIDR_FLAG_RST;
        end else if (clk_en) begin
            resync_flag_r <= resync_flag_nxt;
        end
    end

    // register-map CRC change is a level, not sticky
    // it follows the checker's own compare result
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            regmap_flag_r <= `AIDR_FLAG_RST;
        end else if (clk_en) begin
            regmap_flag_r <= regmap_crc_changed;
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            crcerr_flag_r <= `AIDR_FLAG_RST;
        end else if (clk_en) begin
            crcerr_flag_r <= crcerr_flag_nxt;
        end
    end

    // mode image register; reserved bits are stored too
    // so software reads back exactly what it wrote
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mode_r <= `AIDR_MODE_RST;
        end else if (clk_en) begin
            mode_r <= mode_nxt;
        end
    end

    // reset flag register, set again by every reset
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reset_flag_r <= `AIDR_RESETFLAG_RST;
        end else if (clk_en) begin
            reset_flag_r <= reset_flag_nxt;
        end
    end

    // Interrupt enable register
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_en_r <= {`AIDR_NUM_EVT{1'b0}};
        end else if (clk_en) begin
            irq_en_r <= irq_en_nxt;
        end
    end

    // Interrupt status register; events seen while the clock
    // enable is low are not recorded
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_stat_r <= {`AIDR_NUM_EVT{1'b0}};
        end else if (clk_en) begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // CRC type output; registered so the core sees a clean
    // level, at the price of one cycle behind the mode image
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            crc_type <= `AIDR_CRCTYPE_RST;
        end else if (clk_en) begin
            crc_type <= mode_r[`AIDR_MODE_CRCTYPE];
        end
    end

    // word length output, same one-cycle lag
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            word_length_field <= `AIDR_WLEN_RST;
        end else if (clk_en) begin
            word_length_field <=
                mode_r[`AIDR_MODE_WLEN_LSB+1:`AIDR_MODE_WLEN_LSB];
        end
    end

    // Interrupt output register; a level, cleared only through
    // the clear register or by masking
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq <= `AIDR_FLAG_RST;
        end else if (clk_en) begin
            irq <= irq_nxt;
        end
    end

    // per-channel new-data flags
    // One identical cell per channel; a result finishing in the
    // same cycle as a transfer leaves the flag set, so the host
    // never misses a sample it has not read
    genvar ch;
    generate
        for (ch = 0; ch < `AIDR_NUM_CH; ch = ch + 1) begin : g_ch
            always @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    channel_new_data_flag[ch] <= 1'b0;
                end else if (clk_en) begin
                    // clear on transfer, new result wins
                    if (conv_done[ch]) begin
                        channel_new_data_flag[ch] <= 1'b1;
                    end else if (result_taken[ch]) begin
                        channel_new_data_flag[ch] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: self-checking bench for aidr_regs
// Assumes: host model drives the register port
// Notes: flag model follows set-over-clear
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk = 0, resetn = 0, clk_en = 1, irq, crc_type;
    logic if_locked = 0, resync_pulse = 0, regmap_crc_changed = 0;
    logic rx_crc_error = 0, reg_wr, reg_rd;
    logic [7:0] conv_done = 0, result_taken = 0, channel_new_data_flag;
    logic [7:0] ndx = 0, y;
    logic [5:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, q, x;
    logic [1:0] word_length_field;
    int err_total = 0, n_checks = 0;
    aidr_host h (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata);
    aidr_regs dut_u (.sys_clk, .resetn, .clk_en, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .if_locked, .resync_pulse,
        .regmap_crc_changed, .rx_crc_error, .conv_done, .result_taken,
        .crc_type, .word_length_field, .channel_new_data_flag, .irq);
    task ck(input string n, input [15:0] e, input [15:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %h seen %h", n, e, g);
        end
    endtask
    task ev(input [7:0] c, input [7:0] t, input p);
        @(posedge sys_clk) {conv_done, result_taken} <= {c, t};
        {resync_pulse, rx_crc_error} <= {p, p};
        ndx = (ndx & ~t) | c;
        @(posedge sys_clk) {conv_done, result_taken} <= 16'h0000;
        {resync_pulse, rx_crc_error} <= 2'b00;
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial forever #4 sys_clk = ~sys_clk;
    initial begin
        #50000 err_total++;
        give_verdict;
    end
    initial begin
        void'($urandom(32'h3095c4d4));
        repeat (20) @(posedge sys_clk);
        resetn <= 1;
        h.wr(6'h00, 16'hffff);
        h.wr(6'h01, 16'hffff);
        h.rd(6'h00, q);
        ck("id", 16'h0058, q[15:8]);
        h.rd(6'h01, q);
        ck("status", 16'h0500, q);
        h.rd(6'h02, q);
        ck("mode", 16'h0510, q);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            x = $urandom;
            h.wr(6'h02, {4'h0, x[0], 1'b0, i[1:0], 8'h00});
            ev(x[15:8], x[7:0], 1'b0);
            h.rd(6'h01, q);
            ck("status", {4'h0, x[0], 1'b0, i[1:0], ndx}, q);
            ck("mode out", {x[0], i[1:0]},
               {crc_type, word_length_field});
            ck("flags", ndx, channel_new_data_flag);
        end
        $display("mode test done");
        @(posedge sys_clk) if_locked <= 1;
        regmap_crc_changed <= 1;
        h.wr(6'h31, 16'h0003);
        ev(8'h00, 8'h00, 1'b1);
        h.rd(6'h01, q);
        ck("events", 16'h000f, q[15:12]);
        h.rd(6'h30, q);
        ck("irq stat", 16'h0003, q[1:0]);
        ck("irq on", 16'h0001, irq);
        h.wr(6'h32, 16'h000f);
        repeat (2) @(posedge sys_clk);
        #1 ck("irq cleared", 16'h0000, irq);
        h.wr(6'h31, 16'h0000);
        ev(8'h00, 8'h00, 1'b1);
        repeat (2) @(posedge sys_clk);
        #1 ck("irq masked", 16'h0000, irq);
        // Low clock enable must freeze the new-data flags
        y = ndx;
        @(posedge sys_clk) clk_en <= 0;
        ev(8'hff, 8'h00, 1'b0);
        #1 ck("frozen", y, channel_new_data_flag);
        ndx = y;
        @(posedge sys_clk) clk_en <= 1;
        h.rd(6'h3f, q);
        ck("unmapped", 16'h0000, q);
        $display("event test done");
        give_verdict;
    end
endmodule
`default_nettype wire
